// ### tb/dual_point_and_secure_watchdog_tb.sv
// Self-checking bench for the dual point and secure watchdog
`timescale 1ns/1ns
`default_nettype none
`include "watchdog_event_line_params.svh"
module dual_point_and_secure_watchdog_tb;
  logic clk_i, rst_i, ge, gs, e1, e2, sw, sws, swe, sv, svs, vseen;
  logic [`CNT_W-1:0] gp, g1, g2, sp, sg;
  logic [5:0] ov, prev;
  logic [5:0] q[$];
  logic [7:0] lf;
  int n_fail, checked, n_irq1, n, ex1;

  dual_point_and_secure_watchdog dut (.clk_i(clk_i), .rst_i(rst_i), .gen_enable_i(ge), .gen_service_i(gs),
    .gen_period_i(gp), .gen_point1_i(g1), .gen_point2_i(g2), .gen_irq1_en_i(e1), .gen_irq2_en_i(e2),
    .gen_irq1_o(ov[5]), .gen_irq2_o(ov[4]), .watchdog_event_line_o(ov[3]), .sec_wr_i(sw),
    .sec_wr_secure_i(sws), .sec_wr_enable_i(swe), .sec_wr_period_i(sp), .sec_wr_grace_i(sg),
    .sec_service_i(sv), .sec_service_secure_i(svs), .secure_world_irq_o(ov[2]),
    .security_violation_o(ov[1]), .secure_watchdog_active_o(ov[0]));
  watchdog_event_line_irq_sink sink (.clk_i(clk_i), .rst_i(rst_i), .irq1_i(ov[5]), .violation_i(ov[1]),
    .n_irq1_o(n_irq1), .violation_seen_o(vseen));

  function automatic logic [7:0] nx(input logic [7:0] v);
    nx = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : nx

  task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
    checked++;
    if (s !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic tally_and_finish;
    if (n_fail == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish

  // Wait on one output bit, bounded
  task automatic wt(input int b, input logic v, output int k);
    k = 0;
    while (ov[b] !== v) begin
      @(negedge clk_i);
      k++;
      if (k > 300) begin
        n_fail++;
        tally_and_finish;
      end
    end
  endtask : wt

  task automatic wr(input logic s, input logic en);
    @(posedge clk_i);
    sw <= 1'b1;
    sws <= s;
    swe <= en;
    @(posedge clk_i);
    sw <= 1'b0;
  endtask : wr

  task automatic svc(input logic s);
    @(posedge clk_i);
    sv <= 1'b1;
    svs <= s;
    @(posedge clk_i);
    sv <= 1'b0;
  endtask : svc

  // One general run of two periods, noting what each point raises
  task automatic gen_round(input logic [7:0] r);
    int p;
    p = 12 + r[2:0];
    gp <= `CNT_W'(p);
    g1 <= `CNT_W'(2 + r[4:3]);
    g2 <= `CNT_W'(5 + r[4:3] + r[6:5]);
    e1 <= r[7];
    e2 <= r[5];
    ex1 += 2 * r[7];
    @(posedge clk_i);
    ge <= 1'b1;
    // two points per period, each own enable
    repeat (2) begin
      if (r[7]) q.push_back(6'h20);
      if (r[7]) q.push_back(6'h00);
      q.push_back({1'b0, r[5], 4'h8});
      q.push_back(6'h00);
    end
    repeat (2 * (p + 1)) @(posedge clk_i);
    ge <= 1'b0;
  endtask : gen_round

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // Every output change outside reset must match the oldest note
  always @(negedge clk_i) begin
    if (rst_i) begin
      prev <= ov;
    end else if (ov !== prev) begin
      prev <= ov;
      chk("outputs", ov, q.size() > 0 ? q.pop_front() : 6'hX);
    end
  end

  initial begin
    {rst_i, ge, gs, e1, e2, sw, sws, swe, sv, svs} = 10'h200;
    {gp, g1, g2, sp, sg} = '0;
    lf = nx(8'h4C);
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    gen_round(lf);
    lf = nx(lf);
    gen_round(lf);
    // a held service keeps the counter off both points
    @(posedge clk_i);
    ge <= 1'b1;
    gs <= 1'b1;
    repeat (20) @(posedge clk_i);
    ge <= 1'b0;
    gs <= 1'b0;
    lf = nx(lf);
    sp <= `CNT_W'(2 + lf[1:0]);
    sg <= `CNT_W'(10 + lf[4:3]);
    wr(1'b0, 1'b1);
    repeat (4) @(negedge clk_i);
    chk("nonsecure", ov, 6'h00);
    q.push_back(6'h01);
    q.push_back(6'h05);
    wr(1'b1, 1'b1);
    wt(0, 1'b1, n);
    wt(2, 1'b1, n);
    chk("timeout", n, sp + 1);
    svc(1'b0);
    wr(1'b0, 1'b0);
    q.push_back(6'h01);
    q.push_back(6'h05);
    q.push_back(6'h07);
    svc(1'b1);
    wt(2, 1'b0, n);
    wt(2, 1'b1, n);
    chk("reload", n, sp + 1);
    wt(1, 1'b1, n);
    chk("grace", n, sg + 1);
    wr(1'b1, 1'b0);
    repeat (4) @(negedge clk_i);
    chk("core irq", n_irq1, ex1);
    chk("violation", vseen, 1);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    lf = nx(lf);
    sp <= `CNT_W'(2 + lf[1:0]);
    sg <= `CNT_W'(10 + lf[4:3]);
    @(negedge clk_i);
    chk("reset", ov, 6'h00);
    // a fresh activation after reset times out on the new period
    q.push_back(6'h01);
    q.push_back(6'h05);
    wr(1'b1, 1'b1);
    wt(0, 1'b1, n);
    wt(2, 1'b1, n);
    chk("restart", n, sp + 1);
    // a secure deactivation ends the interrupt
    q.push_back(6'h00);
    wr(1'b1, 1'b0);
    repeat (2) @(negedge clk_i);
    chk("notes left", q.size(), 0);
    tally_and_finish;
  end
endmodule : dual_point_and_secure_watchdog_tb
`default_nettype wire

// ### tb/watchdog_event_line_irq_sink.sv
// Model of the core interrupt intake and the security check unit
`timescale 1ns/1ns
`default_nettype none
module watchdog_event_line_irq_sink (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Events from the watchdog
  input wire logic irq1_i,
  input wire logic violation_i,
  // What the far side has seen
  output var int n_irq1_o,
  output var logic violation_seen_o
);
  // Count core interrupts, latch violations until reset
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      n_irq1_o <= 0;
      violation_seen_o <= 1'b0;
    end else begin
      n_irq1_o <= n_irq1_o + int'(irq1_i);
      violation_seen_o <= violation_seen_o | violation_i;
    end
  end
endmodule : watchdog_event_line_irq_sink
`default_nettype wire

// ### verilog/dual_point_and_secure_watchdog.sv
// Top of the dual point and secure watchdog
// How it works
// - The general watchdog checks two comparison points, each independently, in every period.
// - Each point has its own enable that lets it raise an interrupt to the core.
// - Reaching the second point pulses the external watchdog event line.
// - Once activated the secure watchdog times out if not serviced within its period.
// - The first time-out raises the secure world interrupt.
// - Staying unserviced after that raises the security violation to the security check unit.
// - Non-secure writes to settings or activation are ignored.
`timescale 1ns/1ns
`default_nettype none
`include "watchdog_event_line_params.svh"
module dual_point_and_secure_watchdog
  import watchdog_event_line_pkg::*;
#(
  parameter int W = `CNT_W
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // General watchdog control
  input wire logic gen_enable_i,
  input wire logic gen_service_i,
  input wire logic [W-1:0] gen_period_i,
  input wire logic [W-1:0] gen_point1_i,
  input wire logic [W-1:0] gen_point2_i,
  input wire logic gen_irq1_en_i,
  input wire logic gen_irq2_en_i,
  // General watchdog events
  output logic gen_irq1_o,
  output logic gen_irq2_o,
  output logic watchdog_event_line_o,
  // Secure watchdog access
  input wire logic sec_wr_i,
  input wire logic sec_wr_secure_i,
  input wire logic sec_wr_enable_i,
  input wire logic [W-1:0] sec_wr_period_i,
  input wire logic [W-1:0] sec_wr_grace_i,
  input wire logic sec_service_i,
  input wire logic sec_service_secure_i,
  // Secure watchdog outputs
  output logic secure_world_irq_o,
  output logic security_violation_o,
  output logic secure_watchdog_active_o
);
  // Refuse widths the counters cannot serve
  if (W < 2 || W > 32) begin : g_width_bad
    $error("watchdog width out of range");
  end

  gen_watchdog_event_line #(.W(W)) u_gen (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .enable_i(gen_enable_i),
    .service_i(gen_service_i),
    .period_i(gen_period_i),
    .point1_i(gen_point1_i),
    .point2_i(gen_point2_i),
    .irq1_en_i(gen_irq1_en_i),
    .irq2_en_i(gen_irq2_en_i),
    .irq1_o(gen_irq1_o),
    .irq2_o(gen_irq2_o),
    .event_o(watchdog_event_line_o)
  );

  typedef struct packed {
    sec_state_t state;
    logic [W-1:0] period;
    logic [W-1:0] grace;
    logic [W-1:0] cnt;
  } sec_st_t;

  sec_st_t st_reg;
  sec_st_t st_next;

  logic cfg_ok;
  logic svc_ok;

  // Only secure accesses count
  // non-secure writes ignored
  assign cfg_ok = sec_wr_i && sec_wr_secure_i;
  assign svc_ok = sec_service_i && sec_service_secure_i;

  // Next count value, shared by both escalation stages
  function automatic logic [W-1:0] count_up(input logic [W-1:0] c);
    count_up = c + 1'b1;
  endfunction : count_up

  // Secure watchdog state machine
  // Escalation runs the period, then the grace; only reset leaves the violation
  // stage, so a starved secure side cannot be silenced from the normal side
  always_comb begin
    st_next = st_reg;
    if (cfg_ok) begin
      st_next.period = sec_wr_period_i;
      st_next.grace = sec_wr_grace_i;
    end
    unique case (st_reg.state)
      SEC_OFF: begin
        st_next.cnt = '0;
        if (cfg_ok && sec_wr_enable_i) st_next.state = SEC_RUN;
      end
      SEC_RUN: begin
        if (svc_ok) st_next.cnt = '0;
        else if (st_reg.cnt >= st_reg.period) begin
          st_next.state = SEC_IRQ;
          st_next.cnt = '0;
        end else st_next.cnt = count_up(st_reg.cnt);
      end
      SEC_IRQ: begin
        if (svc_ok) begin
          st_next.state = SEC_RUN;
          st_next.cnt = '0;
        end else if (st_reg.cnt >= st_reg.grace) begin
          st_next.state = SEC_VIOL;
        end else st_next.cnt = count_up(st_reg.cnt);
      end
      SEC_VIOL: begin
        st_next.cnt = st_reg.cnt;
      end
    endcase
    // Secure deactivation, never after violation
    if (cfg_ok && !sec_wr_enable_i && st_reg.state != SEC_VIOL) begin
      st_next.state = SEC_OFF;
      st_next.cnt = '0;
    end
  end

  // State register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg.state <= SEC_OFF;
      st_reg.period <= W'(`SEC_PERIOD_RST);
      st_reg.grace <= W'(`SEC_GRACE_RST);
      st_reg.cnt <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Secure outputs, levels straight from the state register
  // The interrupt stays up through the violation stage so the core keeps being pulled in
  assign secure_world_irq_o = (st_reg.state == SEC_IRQ) || (st_reg.state == SEC_VIOL);
  assign security_violation_o = (st_reg.state == SEC_VIOL);
  assign secure_watchdog_active_o = (st_reg.state != SEC_OFF);

  chk_nonsecure_ignored: assert property (@(posedge clk_i) disable iff (rst_i)
    (sec_wr_i && !sec_wr_secure_i && !svc_ok && st_reg.state == SEC_OFF) |=> st_reg.state == SEC_OFF)
    else $error("non-secure write took effect");

  chk_settings_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    !cfg_ok |=> $stable(st_reg.period) && $stable(st_reg.grace)) else $error("settings changed");

  chk_secure_deact: assert property (@(posedge clk_i) disable iff (rst_i)
    (cfg_ok && !sec_wr_enable_i && st_reg.state != SEC_VIOL) |=> !secure_watchdog_active_o && !secure_world_irq_o)
    else $error("secure deactivation ignored");

  chk_activate: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_reg.state == SEC_OFF && cfg_ok && sec_wr_enable_i) |=> secure_watchdog_active_o && st_reg.cnt == '0)
    else $error("activation did not start");

  chk_timeout_irq: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_reg.state == SEC_RUN && !svc_ok && !cfg_ok && st_reg.cnt >= st_reg.period) |=> secure_world_irq_o)
    else $error("secure irq missed");

  chk_irq_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    (secure_world_irq_o && !svc_ok && !cfg_ok) |=> secure_world_irq_o)
    else $error("secure irq dropped");

  chk_violation: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_reg.state == SEC_IRQ && !svc_ok && !cfg_ok && st_reg.cnt >= st_reg.grace) |=> security_violation_o)
    else $error("violation missed");

  chk_viol_cause: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(security_violation_o) |-> $past(st_reg.state) == SEC_IRQ) else $error("violation without irq");

  chk_viol_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
    security_violation_o |=> security_violation_o)
    else $error("violation dropped");

  chk_deact_refused: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_reg.state == SEC_VIOL && cfg_ok && !sec_wr_enable_i) |=> secure_watchdog_active_o)
    else $error("deactivated after violation");

  chk_service_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_reg.state == SEC_IRQ && svc_ok && !cfg_ok) |=> !secure_world_irq_o && st_reg.cnt == '0)
    else $error("service did not clear");

  chk_nonsecure_svc: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_reg.state == SEC_IRQ && sec_service_i && !sec_service_secure_i && !cfg_ok) |=> secure_world_irq_o)
    else $error("non-secure service cleared irq");

  chk_service_reload: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_reg.state == SEC_RUN && svc_ok && !cfg_ok) |=> st_reg.cnt == '0 && st_reg.state == SEC_RUN)
    else $error("service did not reload");

  // Main scenarios worth seeing
  cov_sec_irq: cover property (@(posedge clk_i) disable iff (rst_i) $rose(secure_world_irq_o));
  cov_sec_viol: cover property (@(posedge clk_i) disable iff (rst_i) $rose(security_violation_o));
  cov_sec_rescue: cover property (@(posedge clk_i) disable iff (rst_i) st_reg.state == SEC_IRQ && svc_ok);
  cov_sec_deact: cover property (@(posedge clk_i) disable iff (rst_i) $fell(secure_watchdog_active_o));
endmodule : dual_point_and_secure_watchdog
`default_nettype wire

// ### verilog/gen_watchdog_event_line.sv
// General watchdog counter with two comparison points
`timescale 1ns/1ns
`default_nettype none
`include "watchdog_event_line_params.svh"
module gen_watchdog_event_line #(
  parameter int W = `CNT_W
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire logic enable_i,
  input wire logic service_i,
  input wire logic [W-1:0] period_i,
  input wire logic [W-1:0] point1_i,
  input wire logic [W-1:0] point2_i,
  input wire logic irq1_en_i,
  input wire logic irq2_en_i,
  // Events
  output logic irq1_o,
  output logic irq2_o,
  output logic event_o
);
  // Refuse widths the counter cannot serve
  if (W < 2 || W > 32) begin : g_width_bad
    $error("gen_watchdog_event_line width out of range");
  end

  typedef struct packed {
    logic [W-1:0] cnt;
    logic irq1;
    logic irq2;
    logic evt;
  } gen_st_t;

  gen_st_t st_reg;
  gen_st_t st_next;

  // Counting and both point checks
  always_comb begin
    st_next = st_reg;
    st_next.irq1 = 1'b0;
    st_next.irq2 = 1'b0;
    st_next.evt = 1'b0;
    if (!enable_i || service_i) begin
      st_next.cnt = '0;
    end else begin
      if (st_reg.cnt >= period_i) st_next.cnt = '0;
      else st_next.cnt = st_reg.cnt + 1'b1;
      if (st_reg.cnt == point1_i && irq1_en_i) st_next.irq1 = 1'b1;
      if (st_reg.cnt == point2_i && irq2_en_i) st_next.irq2 = 1'b1;
      if (st_reg.cnt == point2_i) st_next.evt = 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) st_reg <= '0;
    else st_reg <= st_next;
  end

  assign irq1_o = st_reg.irq1;
  assign irq2_o = st_reg.irq2;
  assign event_o = st_reg.evt;

  chk_point2_event: assert property (@(posedge clk_i) disable iff (rst_i)
    (enable_i && !service_i && st_reg.cnt == point2_i) |=> event_o) else $error("point2 event missed");
  chk_point1_irq: assert property (@(posedge clk_i) disable iff (rst_i)
    irq1_o |-> $past(irq1_en_i) && $past(st_reg.cnt) == $past(point1_i)) else $error("point1 irq spurious");
  cov_point2: cover property (@(posedge clk_i) disable iff (rst_i) event_o);
endmodule : gen_watchdog_event_line
`default_nettype wire

// ### verilog/watchdog_event_line_params.svh
// Constants for the dual point and secure watchdog
`ifndef WATCHDOG_EVENT_LINE_PARAMS_SVH
`define WATCHDOG_EVENT_LINE_PARAMS_SVH
`define CNT_W 16
`define GEN_PERIOD_RST 16'hFFFF
`define GEN_POINT1_RST 16'h8000
`define GEN_POINT2_RST 16'hC000
`define SEC_PERIOD_RST 16'hFFFF
`define SEC_GRACE_RST 16'h1000
`endif

// ### verilog/watchdog_event_line_pkg.sv
// Types for the dual point and secure watchdog
package watchdog_event_line_pkg;
  typedef enum logic [1:0] {
    SEC_OFF = 2'b00,
    SEC_RUN = 2'b01,
    SEC_IRQ = 2'b10,
    SEC_VIOL = 2'b11
  } sec_state_t;
endpackage : watchdog_event_line_pkg
